//--- dcr_pkg.sv
// Constants shared by the DMA channel control register block
package dcr_pkg;

	// ==========================================================
	// Address map inside the first memory BAR
	// ==========================================================
	localparam logic [15:0] H2C_BASE = 16'h0000; // Host-to-card channel 0 group
	localparam logic [15:0] C2H_BASE = 16'h2000; // Card-to-host channel 0 group
	localparam logic [15:0] GRP_STRIDE = 16'h0100; // Distance between channel groups
	localparam logic [15:0] COMMON_OFS = 16'h4000; // Common interrupt control
	localparam logic [15:0] USR_LO = 16'h9000; // Start of user register windows
	localparam logic [15:0] USR_HI = 16'h93ff; // End of user register windows

	// ==========================================================
	// Register offsets within a channel group
	// ==========================================================
	localparam logic [4:0] CTL_OFS = 5'h04; // Engine control
	localparam logic [4:0] NXT_OFS = 5'h08; // Next descriptor pointer
	localparam logic [4:0] SWP_OFS = 5'h0c; // Software descriptor pointer
	localparam logic [4:0] BYTES_OFS = 5'h1c; // Completed byte count

	// ==========================================================
	// Engine control field positions
	// ==========================================================
	localparam int CTL_IE = 0; // Per-engine interrupt enable
	localparam int CTL_ACT = 1; // Interrupt active
	localparam int CTL_DONE = 2; // Descriptor complete
	localparam int CTL_ALIGN = 3; // Descriptor alignment error
	localparam int CTL_FETCH = 4; // Descriptor fetch error
	localparam int CTL_ABORT = 5; // Software abort flag
	localparam int CTL_EN = 8; // Engine enable
	localparam int CTL_RUN = 10; // Transfer in progress
	localparam int CTL_WAIT = 11; // Waiting on descriptors
	localparam int CTL_RREQ = 14; // Reset request to user logic
	localparam int CTL_RST = 15; // Engine and user reset
	localparam int PTR_LSB = 5; // Pointer field low bit
	localparam int PTR_W = 27; // Pointer field width
	localparam int CNT_LSB = 2; // Byte count field low bit
	localparam int CNT_W = 30; // Byte count field width

	// ==========================================================
	// Common register field positions
	// ==========================================================
	localparam int CMN_GIE = 0; // Global interrupt enable
	localparam int CMN_IRQ = 1; // Gated interrupt output
	localparam int CMN_PEND = 2; // Raw interrupt state
	localparam int CMN_MODE = 3; // 1 = legacy wire, 0 = message
	localparam int CMN_UIE = 4; // User interrupt enable
	localparam int CMN_UACT = 5; // User interrupt active
	localparam int CMN_H2C_LSB = 16; // Host-to-card engine status
	localparam int CMN_C2H_LSB = 24; // Card-to-host engine status
	localparam int MAX_PER_DIR = 8; // Status slots per direction

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [31:0] REG_RESET = 32'h0000_0000; // All registers
	localparam logic [PTR_W-1:0] PTR_RESET = 27'h000_0000; // Pointer fields

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int SAMPLE_US = 1_000_000; // Byte count sample period, us
	localparam int MCLK_MHZ = 250; // Core clock rate
	localparam int SAMPLE_CYC = SAMPLE_US * MCLK_MHZ; // Cycles per sample

endpackage

//--- dcr_engine.sv
// Per-engine control, pointer and event flag registers
`timescale 1ns/1ps
`default_nettype none
module dcr_engine
	import dcr_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic wr_ctl,
	input wire logic wr_nxt,
	input wire logic wr_swp,
	input wire logic [31:0] wdata,
	input wire logic ev_done,
	input wire logic ev_align,
	input wire logic ev_fetch,
	input wire logic ev_abort,
	input wire logic mv_busy,
	input wire logic nxt_load,
	input wire logic [dcr_pkg::PTR_W-1:0] nxt_ptr,
	input wire logic rst_ack,
	output logic [31:0] ctl_rd,
	output logic [31:0] nxt_rd,
	output logic [31:0] swp_rd,
	output logic go,
	output logic irq,
	output logic rreq,
	output logic rst
);
	import dcr_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	logic ie_q, ie_d; // Interrupt enable
	logic [5:1] flg_q, flg_d; // W1C flags, bit positions as read
	logic en_q, en_d; // Engine enable
	logic busy_q, busy_d; // Registered mover status
	logic rreq_q, rreq_d; // Reset request
	logic rst_q, rst_d; // Engine reset
	logic go_q, go_d; // Descriptors pending
	logic irq_q, irq_d; // Engine interrupt request
	logic [PTR_W-1:0] nxt_q, nxt_d; // Next descriptor pointer
	logic [PTR_W-1:0] swp_q, swp_d; // Software descriptor pointer
	logic [5:1] w1c; // Bits software clears this cycle
	logic [5:1] evs; // Events arriving this cycle

	// ==========================================================
	// Next-state logic
	// ==========================================================
	always_comb
	begin
		w1c = wr_ctl ? wdata[5:1] : 5'h00;
		// Every event except abort also raises the active bit
		evs[CTL_DONE] = ev_done;
		evs[CTL_ALIGN] = ev_align;
		evs[CTL_FETCH] = ev_fetch;
		evs[CTL_ABORT] = ev_abort;
		evs[CTL_ACT] = ev_done | ev_align | ev_fetch;
		ie_d = wr_ctl ? wdata[CTL_IE] : ie_q;
		// Set wins over clear so no event is lost
		flg_d = (flg_q & ~w1c) | evs;
		en_d = wr_ctl ? wdata[CTL_EN] : en_q;
		rst_d = wr_ctl ? wdata[CTL_RST] : rst_q;
		// Software write sets or clears; acknowledge clears
		if (wr_ctl)
		begin
			rreq_d = wdata[CTL_RREQ];
		end
		else if (rst_ack)
		begin
			rreq_d = 1'b0;
		end
		else
		begin
			rreq_d = rreq_q;
		end
		// Pointer writable only while disabled
		if (wr_nxt && !en_q)
		begin
			nxt_d = wdata[31:PTR_LSB];
		end
		else if (nxt_load)
		begin
			nxt_d = nxt_ptr; // Mover advancing the chain
		end
		else
		begin
			nxt_d = nxt_q;
		end
		swp_d = wr_swp ? wdata[31:PTR_LSB] : swp_q;
		busy_d = mv_busy;
		// Engine reset clears working state, keeps itself
		if (rst_q)
		begin
			ie_d = 1'b0;
			flg_d = 5'h00;
			en_d = 1'b0;
		end
		go_d = en_d & ~rst_d & (nxt_d != swp_d);
		irq_d = ie_d & (|flg_d);
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			ie_q <= 1'b0;
			flg_q <= 5'h00;
			en_q <= 1'b0;
			busy_q <= 1'b0;
			rreq_q <= 1'b0;
			rst_q <= 1'b0;
			go_q <= 1'b0;
			irq_q <= 1'b0;
			nxt_q <= PTR_RESET;
			swp_q <= PTR_RESET;
		end
		else
		begin
			ie_q <= ie_d;
			flg_q <= flg_d;
			en_q <= en_d;
			busy_q <= busy_d;
			rreq_q <= rreq_d;
			rst_q <= rst_d;
			go_q <= go_d;
			irq_q <= irq_d;
			nxt_q <= nxt_d;
			swp_q <= swp_d;
		end
	end

	// ==========================================================
	// Read views; low pointer bits force 32-byte alignment
	// ==========================================================
	assign ctl_rd = {16'h0000, rst_q, rreq_q, 2'b00,
		en_q & ~busy_q & (nxt_q == swp_q), busy_q, 1'b0, en_q, 2'b00,
		flg_q, ie_q};
	assign nxt_rd = {nxt_q, 5'h00};
	assign swp_rd = {swp_q, 5'h00};
	assign go = go_q;
	assign irq = irq_q;
	assign rreq = rreq_q;
	assign rst = rst_q;
endmodule
`default_nettype wire

//--- dcr_rate.sv
// One-second completed byte counter with sample count
`timescale 1ns/1ps
`default_nettype none
module dcr_rate
	import dcr_pkg::*;
#(
	parameter int WORDS_W = 4
)
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic tick,
	input wire logic words_vld,
	input wire logic [WORDS_W-1:0] words,
	output logic [31:0] cnt_rd
);
	import dcr_pkg::*;

	// ==========================================================
	// State: running total and last published sample
	// ==========================================================
	logic [CNT_W-1:0] acc_q, acc_d; // Words in current second
	logic [CNT_W-1:0] cnt_q, cnt_d; // Words in previous second
	logic [1:0] smp_q, smp_d; // Sample count
	logic [CNT_W-1:0] add; // This cycle's words

	// Counts 4-byte words; the total wraps if a second overflows
	always_comb
	begin
		add = words_vld ? CNT_W'(words) : '0;
		acc_d = acc_q + add;
		cnt_d = cnt_q;
		smp_d = smp_q;
		if (tick)
		begin
			cnt_d = acc_q + add;
			acc_d = '0;
			smp_d = smp_q + 2'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			acc_q <= '0;
			cnt_q <= '0;
			smp_q <= 2'h0;
		end
		else
		begin
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			smp_q <= smp_d;
		end
	end

	assign cnt_rd = {cnt_q, smp_q};
endmodule
`default_nettype wire

//--- dcr_top.sv
// DMA channel control and common interrupt registers in the first BAR
//
// Overview of operation
// - All registers decode inside first memory BAR
// - Channel groups at 0x0, 0x100, 0x2000, 0x2100
// - Common interrupt registers at offset 0x4000
// - User windows reserved from 0x9000 to 0x93FF
// - Bit0 gates interrupts; bit1 sticky, write-one clears
// - Completion descriptor sets bit2, raises interrupt
// - Unaligned descriptor aborts, sets bit3, interrupts
// - Failed descriptor fetch sets bit4, interrupts
// - Software abort sets sticky bit5 flag
// - Enabled engine runs while pointers differ
// - Bit10 shows running, bit11 shows waiting
// - Bit14 requests user reset; acknowledge clears
// - Bit15 resets engine and user logic
// - Next pointer writable only while engine disabled
// - Low five pointer bits read zero
// - Bits 31:2 give last second's words
// - Bits 1:0 count captured samples
// - Common bit0 enables interrupts for all engines
// - Bit1 gated interrupt, bit2 raw pending
// - Bit3 reports legacy or message interrupts
// - Common bit4 enables user interrupts
// - Common bit5 user interrupt active, write-one clears
// - Bits 23:16, 31:24 per-engine status, absent zero
`timescale 1ns/1ps
`default_nettype none
module dcr_top
	import dcr_pkg::*;
#(
	parameter int NUM_H2C = 2,
	parameter int NUM_C2H = 2,
	parameter int WORDS_W = 4,
	parameter int SEC_CYCLES = dcr_pkg::SAMPLE_CYC
)
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic bar0_hit,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	output logic usr_wr,
	output logic usr_rd,
	output logic [15:0] usr_addr,
	output logic [31:0] usr_wdata,
	input wire logic [31:0] usr_rdata,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_done,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_align_err,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_fetch_err,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_abort,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_busy,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_nxt_load,
	input wire logic [(NUM_H2C+NUM_C2H)*dcr_pkg::PTR_W-1:0] mv_nxt_ptr,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_words_vld,
	input wire logic [(NUM_H2C+NUM_C2H)*WORDS_W-1:0] mv_words,
	output logic [NUM_H2C+NUM_C2H-1:0] eng_go,
	output logic [NUM_H2C+NUM_C2H-1:0] eng_rst,
	output logic [NUM_H2C+NUM_C2H-1:0] user_rst_req,
	output logic [NUM_H2C+NUM_C2H-1:0] user_rst,
	input wire logic [NUM_H2C+NUM_C2H-1:0] user_rst_ack,
	input wire logic user_irq_req,
	input wire logic legacy_mode_pin,
	output logic irq_out
);
	import dcr_pkg::*;

	localparam int NE = NUM_H2C + NUM_C2H; // Engines in total

	// ==========================================================
	// Decode helpers
	// ==========================================================

	// Group base of engine i: host-to-card first, then card-to-host
	function automatic logic [15:0] grp_base(input int i);
		logic [15:0] b;
		if (i < NUM_H2C)
		begin
			b = H2C_BASE + 16'(i) * GRP_STRIDE;
		end
		else
		begin
			b = C2H_BASE + 16'(i - NUM_H2C) * GRP_STRIDE;
		end
		return b;
	endfunction

	// True when the address falls in the 32-byte group of engine i
	function automatic logic eng_sel(input logic [15:0] a, input int i);
		logic [15:0] b;
		b = grp_base(i);
		return (a[15:5] == b[15:5]);
	endfunction

	// ==========================================================
	// Request qualification
	// ==========================================================
	logic wr_ok; // Write aimed at this BAR
	logic rd_ok; // Read aimed at this BAR
	logic in_usr; // Address in user windows
	logic in_cmn; // Address is the common register
	assign wr_ok = reg_wr & bar0_hit;
	assign rd_ok = reg_rd & bar0_hit;
	assign in_usr = (reg_addr >= USR_LO) && (reg_addr <= USR_HI);
	assign in_cmn = (reg_addr == COMMON_OFS);

	// ==========================================================
	// Engines and their byte counters
	// ==========================================================
	logic [31:0] ctl_rd [NE]; // Engine control views
	logic [31:0] nxt_rd [NE]; // Next pointer views
	logic [31:0] swp_rd [NE]; // Software pointer views
	logic [31:0] cnt_rd [NE]; // Byte count views
	logic [NE-1:0] eng_irq; // Per-engine interrupt requests
	logic [NE-1:0] rst_w; // Engine reset bits
	logic tick_q, tick_d; // One-second sample pulse

	for (genvar g = 0; g < NE; g++)
	begin : g_eng
		logic hit; // Write hits this engine group
		assign hit = wr_ok & eng_sel(reg_addr, g);
		dcr_engine u_eng (
			.mclk(mclk),
			.reset_n(reset_n),
			.wr_ctl(hit && reg_addr[4:0] == CTL_OFS),
			.wr_nxt(hit && reg_addr[4:0] == NXT_OFS),
			.wr_swp(hit && reg_addr[4:0] == SWP_OFS),
			.wdata(reg_wdata),
			.ev_done(mv_done[g]),
			.ev_align(mv_align_err[g]),
			.ev_fetch(mv_fetch_err[g]),
			.ev_abort(mv_abort[g]),
			.mv_busy(mv_busy[g]),
			.nxt_load(mv_nxt_load[g]),
			.nxt_ptr(mv_nxt_ptr[g*PTR_W +: PTR_W]),
			.rst_ack(user_rst_ack[g]),
			.ctl_rd(ctl_rd[g]),
			.nxt_rd(nxt_rd[g]),
			.swp_rd(swp_rd[g]),
			.go(eng_go[g]),
			.irq(eng_irq[g]),
			.rreq(user_rst_req[g]),
			.rst(rst_w[g])
		);
		dcr_rate #(
			.WORDS_W(WORDS_W)
		) u_rate (
			.mclk(mclk),
			.reset_n(reset_n),
			.tick(tick_q),
			.words_vld(mv_words_vld[g]),
			.words(mv_words[g*WORDS_W +: WORDS_W]),
			.cnt_rd(cnt_rd[g])
		);
	end

	// Same flop feeds both; the mover and user logic see one reset
	assign eng_rst = rst_w;
	assign user_rst = rst_w;

	// ==========================================================
	// One-second divider shared by all byte counters
	// ==========================================================
	logic [31:0] sec_q, sec_d; // Cycles into the second

	always_comb
	begin
		tick_d = (sec_q == 32'(SEC_CYCLES - 1));
		sec_d = tick_d ? 32'h0000_0000 : sec_q + 32'h0000_0001;
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			sec_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end
		else
		begin
			sec_q <= sec_d;
			tick_q <= tick_d;
		end
	end

	// ==========================================================
	// Interrupt mode strap, synchronised before use
	// ==========================================================
	logic mode_s1_q; // First stage, read only by second
	logic mode_q; // Stable mode level

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			mode_s1_q <= 1'b0;
			mode_q <= 1'b0;
		end
		else
		begin
			mode_s1_q <= legacy_mode_pin;
			mode_q <= mode_s1_q;
		end
	end

	// ==========================================================
	// Common interrupt control
	// ==========================================================
	logic gie_q, gie_d; // Global interrupt enable
	logic uie_q, uie_d; // User interrupt enable
	logic uact_q, uact_d; // User interrupt active
	logic pend_q, pend_d; // Raw interrupt state
	logic irq_q, irq_d; // Gated interrupt output
	logic [MAX_PER_DIR-1:0] h2c_st; // Host-to-card status slots
	logic [MAX_PER_DIR-1:0] c2h_st; // Card-to-host status slots
	logic cmn_wr; // Write to the common register

	assign cmn_wr = wr_ok & in_cmn;

	always_comb
	begin
		// Absent engines leave their slots at zero
		h2c_st = '0;
		c2h_st = '0;
		for (int i = 0; i < NUM_H2C; i++)
		begin
			h2c_st[i] = eng_irq[i];
		end
		for (int i = 0; i < NUM_C2H; i++)
		begin
			c2h_st[i] = eng_irq[NUM_H2C + i];
		end
		gie_d = cmn_wr ? reg_wdata[CMN_GIE] : gie_q;
		uie_d = cmn_wr ? reg_wdata[CMN_UIE] : uie_q;
		// Request sets, write-one clears, set wins
		uact_d = (uact_q & ~(cmn_wr & reg_wdata[CMN_UACT]))
			| (user_irq_req & uie_q);
		pend_d = (|eng_irq) | uact_q;
		irq_d = gie_q & pend_d;
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			gie_q <= 1'b0;
			uie_q <= 1'b0;
			uact_q <= 1'b0;
			pend_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			gie_q <= gie_d;
			uie_q <= uie_d;
			uact_q <= uact_d;
			pend_q <= pend_d;
			irq_q <= irq_d;
		end
	end

	assign irq_out = irq_q;

	// ==========================================================
	// Read path and user window forwarding
	// ==========================================================
	// Core registers answer one cycle after the request, user
	// windows two; user logic must drive its data in the cycle usr_rd is high.
	logic [31:0] rdata_q, rdata_d; // Read answer
	logic rvalid_q, rvalid_d; // Answer strobe
	logic uwr_q, uwr_d; // Forwarded user write
	logic urd_q, urd_d; // Forwarded user read
	logic [15:0] uaddr_q, uaddr_d; // Forwarded address
	logic [31:0] uwdata_q, uwdata_d; // Forwarded write data
	logic [31:0] cmn_rd; // Common register view

	assign cmn_rd = {c2h_st, h2c_st, 10'h000, uact_q, uie_q, mode_q,
		pend_q, irq_q, gie_q};

	always_comb
	begin
		// Answer holds until the next one replaces it
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		uwr_d = wr_ok & in_usr;
		urd_d = rd_ok & in_usr;
		uaddr_d = (wr_ok | rd_ok) & in_usr ? reg_addr : uaddr_q;
		uwdata_d = (wr_ok & in_usr) ? reg_wdata : uwdata_q;
		if (urd_q)
		begin
			rdata_d = usr_rdata; // User answer, second cycle
			rvalid_d = 1'b1;
		end
		else if (rd_ok && !in_usr)
		begin
			rvalid_d = 1'b1;
			rdata_d = in_cmn ? cmn_rd : REG_RESET;
			for (int i = 0; i < NE; i++)
			begin
				if (eng_sel(reg_addr, i))
				begin
					case (reg_addr[4:0])
						CTL_OFS: rdata_d = ctl_rd[i];
						NXT_OFS: rdata_d = nxt_rd[i];
						SWP_OFS: rdata_d = swp_rd[i];
						BYTES_OFS: rdata_d = cnt_rd[i];
						default: rdata_d = REG_RESET; // Holes read zero
					endcase
				end
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			rdata_q <= REG_RESET;
			rvalid_q <= 1'b0;
			uwr_q <= 1'b0;
			urd_q <= 1'b0;
			uaddr_q <= 16'h0000;
			uwdata_q <= REG_RESET;
		end
		else
		begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			uwr_q <= uwr_d;
			urd_q <= urd_d;
			uaddr_q <= uaddr_d;
			uwdata_q <= uwdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign usr_wr = uwr_q;
	assign usr_rd = urd_q;
	assign usr_addr = uaddr_q;
	assign usr_wdata = uwdata_q;
endmodule
`default_nettype wire

//--- dcr_monitor.sv
// Port checker for the DMA channel control register block
`timescale 1ns/1ps
`default_nettype none
module dcr_monitor #(parameter int NUM_H2C = 2, parameter int NUM_C2H = 2)
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic bar0_hit,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic usr_rd,
	input wire logic [15:0] usr_addr,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_done,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_align_err,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_fetch_err,
	input wire logic [NUM_H2C+NUM_C2H-1:0] mv_abort,
	input wire logic [NUM_H2C+NUM_C2H-1:0] eng_go,
	input wire logic [NUM_H2C+NUM_C2H-1:0] eng_rst,
	input wire logic [NUM_H2C+NUM_C2H-1:0] user_rst,
	input wire logic [NUM_H2C+NUM_C2H-1:0] user_rst_req,
	input wire logic [NUM_H2C+NUM_C2H-1:0] user_rst_ack,
	input wire logic user_irq_req,
	input wire logic irq_out
);
	// ==========================================================
	// Helpers
	// ==========================================================
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	wire in_usr = (reg_addr >= 16'h9000) && (reg_addr <= 16'h93ff); // User window hit
	logic [3:0] cause_q; // Recent interrupt causes, longest path is two cycles
	always_ff @(posedge mclk)
		cause_q <= reset_n ? {cause_q[2:0], |{mv_done, mv_align_err, mv_fetch_err, mv_abort,
			user_irq_req, reg_wr}} : 4'h0;
	// ==========================================================
	// Assertions
	// ==========================================================
	a_core_answer: assert property (bar0_hit && reg_rd && !in_usr |=> reg_rvalid && !usr_rd)
		else $error("core read not answered next cycle");
	a_no_stray_ans: assert property (!(bar0_hit && (reg_rd || reg_wr)) && !usr_rd |=> !reg_rvalid)
		else $error("answer without a read");
	a_user_fwd: assert property (bar0_hit && reg_rd && in_usr
		|=> usr_rd && usr_addr == $past(reg_addr) ##1 reg_rvalid)
		else $error("user window read not forwarded");
	a_rst_pair: assert property (eng_rst == user_rst && (eng_rst & $past(eng_rst) & eng_go) == '0)
		else $error("engine reset not shared or engine runs in reset");
	a_ack_clears: assert property (|(user_rst_req & user_rst_ack) && !reg_wr
		|=> (user_rst_req & $past(user_rst_ack)) == '0)
		else $error("acknowledge did not clear reset request");
	a_req_source: assert property (|(user_rst_req & ~$past(user_rst_req)) |-> $past(reg_wr && bar0_hit))
		else $error("reset request rose without a write");
	a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved without an answer");
	a_irq_cause: assert property ($rose(irq_out) |-> |cause_q)
		else $error("interrupt rose without a cause");
endmodule
bind dcr_top dcr_monitor #(.NUM_H2C(NUM_H2C), .NUM_C2H(NUM_C2H)) mon (.*);
`default_nettype wire

//--- dcr_user_model.sv
// Behavioural user logic: reset handshake and user register answers
`timescale 1ns/1ps
`default_nettype none
module dcr_user_model #(parameter int NE = 4, parameter int ACK_DLY = 3)
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic usr_rd,
	input wire logic [15:0] usr_addr,
	input wire logic [NE-1:0] user_rst_req,
	output logic [NE-1:0] user_rst_ack = '0,
	output logic [31:0] usr_rdata
);
	int cnt [NE]; // Cycles each request has waited
	logic [31:0] junk_q = 32'h0; // Toggles so idle data never looks valid
	// Answer only while selected, a tag plus the address
	assign usr_rdata = usr_rd ? {16'ha5a5, usr_addr} : junk_q;
	// Slow acknowledge, one pulse per request
	always @(posedge mclk)
	begin
		junk_q <= ~junk_q;
		for (int g = 0; g < NE; g++)
		begin
			if (!reset_n || !user_rst_req[g])
				cnt[g] = 0;
			else if (cnt[g] < ACK_DLY)
				cnt[g]++;
			user_rst_ack[g] <= user_rst_req[g] && cnt[g] == ACK_DLY - 1;
		end
	end
endmodule
`default_nettype wire

//--- dma_channel_control_regs_bench.sv
// Self-checking bench for the DMA channel control registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module dma_channel_control_regs_bench;
	import dcr_pkg::*;
	// ==========================================================
	// Signals, named as the ports
	// ==========================================================
	logic mclk = 0, reset_n = 0, bar0_hit = 0, reg_wr = 0, reg_rd = 0, user_irq_req = 0;
	logic legacy_mode_pin = 1; // Wire interrupt strap
	logic [15:0] reg_addr = '0, usr_addr;
	logic [31:0] reg_wdata = '0, reg_rdata, usr_wdata, usr_rdata, lf = 32'h448e, d, e;
	logic reg_rvalid, usr_wr, usr_rd, irq_out;
	logic [3:0] mv_done = '0, mv_align_err = '0, mv_fetch_err = '0, mv_abort = '0, mv_busy = '0;
	logic [3:0] mv_nxt_load = '0, mv_words_vld = '0, eng_go, eng_rst, user_rst_req, user_rst;
	logic [3:0] user_rst_ack;
	logic [107:0] mv_nxt_ptr = '0;
	logic [15:0] mv_words = '0;
	logic [31:0] expq [$]; // Expected read answers, oldest first
	int errors = 0, cmp_count = 0;
	localparam logic [15:0] BASE [4] = '{16'h0000, 16'h0100, 16'h2000, 16'h2100};
	always #2 mclk = ~mclk;
	// Short sample period keeps the run brief
	dcr_top #(.SEC_CYCLES(20)) dut (.*);
	dcr_user_model #(.NE(4)) peer (.*);
	// ==========================================================
	// Tasks
	// ==========================================================
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction
	// Always lands just after an edge
	task automatic cyc(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(logic [15:0] a, logic [31:0] v);
		{reg_wr, bar0_hit, reg_addr, reg_wdata} = {2'b11, a, v};
		cyc(1);
		{reg_wr, bar0_hit} = 2'b00;
		cyc(1);
	endtask
	// Two idle cycles after every read suit the user window too
	task automatic rd(logic [15:0] a, logic [31:0] v);
		expq.push_back(v);
		{reg_rd, bar0_hit, reg_addr} = {2'b11, a};
		cyc(1);
		{reg_rd, bar0_hit} = 2'b00;
		cyc(2);
	endtask
	task automatic pulse(int k, int g);
		{mv_abort[g], mv_fetch_err[g], mv_align_err[g], mv_done[g]} = 4'h1 << k;
		cyc(1);
		{mv_abort, mv_fetch_err, mv_align_err, mv_done} = '0;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Answer watcher
	// ==========================================================
	always @(posedge mclk)
		if (reg_rvalid === 1'b1)
		begin
			e = (expq.size() > 0) ? expq.pop_front() : ~reg_rdata; // Stray answer fails
			`CHK(reg_rdata, e)
		end
	// Hang guard
	initial
	begin
		repeat (5000) @(posedge mclk);
		errors++;
		summarize();
	end
	// ==========================================================
	// Scenarios
	// ==========================================================
	initial
	begin
		cyc(6);
		reset_n = 1;
		// Five words before the first sample, none in the next period
		cyc(1);
		{mv_words_vld[0], mv_words[3:0]} = 5'h15;
		cyc(1);
		mv_words_vld = '0;
		cyc(22);
		rd(16'h001c, 32'h15);
		cyc(17);
		rd(16'h001c, 32'h2);
		$display("byte count test done");
		for (int i = 0; i < 4; i++)
			for (int r = 4; r <= 12; r += 4)
				rd(BASE[i] + 16'(r), 32'h0);
		rd(16'h4000, 32'h8);
		rd(16'h0010, 32'h0);
		rd(16'h3000, 32'h0);
		$display("map test done");
		// Pointers of channel 1, low bits forced to zero
		d = rnd();
		wr(16'h0108, d);
		wr(16'h010c, ~d);
		rd(16'h0108, d & ~32'h1f);
		rd(16'h010c, ~d & ~32'h1f);
		wr(16'h0104, 32'h100);
		cyc(1);
		`CHK(eng_go[1], 1'b1)
		wr(16'h0108, 32'h0);
		rd(16'h0108, d & ~32'h1f);
		mv_busy[1] = 1;
		cyc(2);
		rd(16'h0104, 32'h500);
		mv_busy = '0;
		wr(16'h010c, d);
		cyc(2);
		rd(16'h0104, 32'h900);
		`CHK(eng_go[1], 1'b0)
		// Mover advances the chain while enabled
		{mv_nxt_load[1], mv_nxt_ptr[53:27]} = {1'b1, ~d[31:5]};
		cyc(1);
		mv_nxt_load = '0;
		cyc(1);
		`CHK(eng_go[1], 1'b1)
		rd(16'h0108, ~d & ~32'h1f);
		$display("pointer test done");
		// Every event kind on card-to-host channel 0
		wr(16'h2004, 32'h1);
		for (int k = 0; k < 4; k++)
		begin
			pulse(k, 2);
			cyc(3);
			rd(16'h2004, 32'h1 | (32'h4 << k) | (k < 3 ? 32'h2 : 32'h0));
			rd(16'h4000, 32'h0100_000c);
			wr(16'h2004, 32'h3f);
		end
		pulse(0, 2);
		wr(16'h4000, 32'h1);
		cyc(3);
		`CHK(irq_out, 1'b1)
		rd(16'h4000, 32'h0100_000f);
		wr(16'h2004, 32'h3e);
		pulse(0, 2);
		cyc(4);
		`CHK(irq_out, 1'b0)
		rd(16'h2004, 32'h6);
		wr(16'h2004, 32'h3e);
		$display("event test done");
		// Reset request handshake and engine reset
		wr(16'h2104, 32'h4000);
		`CHK(user_rst_req[3], 1'b1)
		cyc(8);
		`CHK(user_rst_req[3], 1'b0)
		wr(16'h2104, 32'h8101);
		cyc(1);
		`CHK({eng_rst[3], user_rst[3]}, 2'b11)
		rd(16'h2104, 32'h8000);
		wr(16'h2104, 32'h0);
		$display("reset test done");
		// User window and user interrupt
		rd(16'h9104, 32'ha5a5_9104);
		{reg_wr, bar0_hit, reg_addr, reg_wdata} = {2'b11, 16'h9300, d};
		cyc(1);
		{reg_wr, bar0_hit} = 2'b00;
		`CHK({usr_wr, usr_addr, usr_wdata}, {1'b1, 16'h9300, d})
		cyc(1);
		wr(16'h4000, 32'h10);
		user_irq_req = 1;
		cyc(1);
		user_irq_req = 0;
		cyc(3);
		rd(16'h4000, 32'h3c);
		legacy_mode_pin = 0;
		wr(16'h4000, 32'h30);
		cyc(3);
		rd(16'h4000, 32'h10);
		$display("user test done");
		cyc(4);
		`CHK(expq.size(), 0)
		summarize();
	end
endmodule
`default_nettype wire
